/* File: move_profile_pkg.sv */
// shared constants and types for the move profile and homing block
package move_profile_pkg;

  // ---------------------------------------------------------------------
  // clock, rate tick and timing
  // ---------------------------------------------------------------------
  localparam int CLK_HZ = 32'h0262_5A00;        // 40 MHz system clock
  localparam int RATE_SCALE = 32'h0000_03E8;    // ms per s, rate x1000
  localparam int TICK_MS = 32'h0000_0001;       // speed update period
  localparam int TICK_CYCLES = CLK_HZ / RATE_SCALE * TICK_MS;
  localparam int HOME_WAIT_S = 32'h0000_0002;   // pause after each stop
  localparam logic [11:0] HOME_WAIT_TICKS =
    12'(HOME_WAIT_S * RATE_SCALE / TICK_MS);
  localparam int HOME_PCT = 32'h0000_000A;      // homing speed percent
  localparam int PCT_FULL = 32'h0000_0064;

  // ---------------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------------
  localparam int SPD_W = 24;                    // steps per second
  localparam int RATE_W = 16;                   // steps/s per ms
  localparam int POS_W = 32;
  localparam int PH_W = 27;                     // step phase accumulator
  localparam int DIV_W = 16;
  localparam logic [PH_W-1:0] PH_WRAP = PH_W'(CLK_HZ);

  // ---------------------------------------------------------------------
  // commands and states
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_MOVE = 2'h0,
    OP_PRESET = 2'h1,
    OP_HOME_CW = 2'h2,
    OP_HOME_CCW = 2'h3
  } op_t;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_RUN = 9'h002,
    ST_SEEK = 9'h004,
    ST_STOP1 = 9'h008,
    ST_WAIT1 = 9'h010,
    ST_BACK = 9'h020,
    ST_STOP2 = 9'h040,
    ST_WAIT2 = 9'h080,
    ST_RET = 9'h100
  } state_t;

endpackage : move_profile_pkg

/* File: ramp_if.sv */
// link between the profile sequencer and the speed ramp generator
`timescale 1ns/10ps
`default_nettype none
interface ramp_if;
  import move_profile_pkg::*;
  logic tick;                  // one-cycle millisecond rate pulse
  logic decel;                 // ramp down toward tgt as a floor
  logic clr;                   // force speed to zero
  logic [SPD_W-1:0] tgt;       // speed goal or floor
  logic [RATE_W-1:0] acc;      // acceleration per tick
  logic [RATE_W-1:0] dec;      // deceleration per tick
  logic [SPD_W-1:0] speed;     // present commanded speed
  modport ctl (output decel, clr, tgt, acc, dec, input tick, speed);
  modport gen (input decel, clr, tgt, acc, dec, output tick, speed);
endinterface : ramp_if
`default_nettype wire

/* File: speed_ramp.sv */
// millisecond tick divider and linear speed ramp
`timescale 1ns/10ps
`default_nettype none
module speed_ramp
  import move_profile_pkg::*;
#(
  parameter logic [DIV_W-1:0] TICKS = DIV_W'(TICK_CYCLES)
) (
  input wire logic ref_clk,  // system clock
  input wire logic rstn,     // synchronous reset, active low
  ramp_if.gen r              // ramp control and speed
);

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic tick;
    logic [SPD_W-1:0] speed;
  } ramp_state_t;

  ramp_state_t s;
  ramp_state_t next_s;
  logic [SPD_W:0] up;
  logic [SPD_W:0] floor_hi;
  logic [SPD_W:0] down_hi;

  // -----------------------------------------------------------------------
  // divider and speed update
  // -----------------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    up = {1'b0, s.speed} + {{(SPD_W+1-RATE_W){1'b0}}, r.acc};
    floor_hi = {1'b0, r.tgt} + {{(SPD_W+1-RATE_W){1'b0}}, r.dec};
    down_hi = {1'b0, s.speed} - {{(SPD_W+1-RATE_W){1'b0}}, r.dec};
    if (s.div == TICKS - 1'b1) begin
      next_s.div = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.div = s.div + 1'b1;
    end
    if (r.clr) begin
      next_s.speed = '0;
    end else if (s.tick) begin
      // update in the cycle the tick is visible, so the sequencer and
      // the speed change agree on which cycle carries the rate step
      // one rate step per tick, clamped at the goal
      if (r.decel || s.speed > r.tgt) begin
        next_s.speed = ({1'b0, s.speed} > floor_hi) ?
          down_hi[SPD_W-1:0] : r.tgt;
      end else if (up > {1'b0, r.tgt}) begin
        next_s.speed = r.tgt;
      end else begin
        next_s.speed = up[SPD_W-1:0];
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign r.tick = s.tick;
  assign r.speed = s.speed;

  // -----------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------
  a_linear_ramp_up: assert property (@(posedge ref_clk) disable iff (!rstn)
    (s.tick && !r.clr && !r.decel && up <= {1'b0, r.tgt})
    |=> s.speed == $past(up[SPD_W-1:0]))
    else $error("speed did not rise by the acceleration step");

  a_tick_period: assert property (@(posedge ref_clk) disable iff (!rstn)
    s.tick |=> !s.tick)
    else $error("rate tick lasted more than one cycle");

endmodule : speed_ramp
`default_nettype wire

/* File: move_profile_homing.sv */
// move profile generator with position preset and home search
//
// Overview of operation
// - Acceleration and deceleration are in steps/s per ms; times 1000 in steps/s^2.
// - Speed ramps linearly up toward the programmed speed and linearly down.
// - When ramp-up plus ramp-down steps are below the length, a flat run is made.
// - When they equal the length, programmed speed is reached and held one step.
// - When they exceed the length, decel starts before programmed speed.
// - The flat run lasts the length minus the ramp-up and ramp-down steps.
// - A finished home search sets the profile position to zero.
// - Presetting or homing loads the encoder position with the same value.
// - The final homing segment runs at ten percent of the commanded speed.
// - Preset loads both positions; the host keeps the value in 31-bit signed range.
// - A clockwise home search starts by turning clockwise, or counter-clockwise off home when home is already active.
// - A clockwise search ends only on a home trigger while clockwise at homing speed.
// - A counter-clockwise search mirrors the clockwise one.
// - Search, stop, wait 2 s, reverse off home, stop, wait 2 s, return slowly.
`timescale 1ns/10ps
`default_nettype none
module move_profile_homing
  import move_profile_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES      // clock cycles per rate tick
) (
  input wire logic ref_clk,                 // 40 MHz system clock
  input wire logic rstn,                    // synchronous reset, active low
  input wire logic cmd_valid,               // command offered
  output logic cmd_ready,                   // idle, command taken
  input wire op_t cmd_op,                   // command code
  input wire logic [POS_W-1:0] cmd_value,   // move distance or preset
  input wire logic [SPD_W-1:0] cmd_speed,   // programmed speed
  input wire logic [RATE_W-1:0] cmd_accel,  // acceleration
  input wire logic [RATE_W-1:0] cmd_decel,  // deceleration
  output logic cmd_done,                    // command finished pulse
  output logic busy,                        // motion in progress
  input wire logic home_in,                 // home sensor pin, active high
  output logic step_pulse,                  // one step pulse
  output logic step_cw,                     // direction, high clockwise
  output logic [SPD_W-1:0] speed_now,       // commanded speed
  output logic [POS_W-1:0] profile_pos,     // profile position
  output logic enc_load,                    // encoder load pulse
  output logic [POS_W-1:0] enc_value        // encoder load value
);

  typedef struct packed {
    state_t st;
    logic [POS_W-1:0] pos;
    logic [POS_W-1:0] enc;
    logic enc_ld;
    logic [POS_W-1:0] rem;
    logic dir;
    logic hdir;
    logic [PH_W-1:0] ph;
    logic step;
    logic done;
    logic [11:0] wcnt;
    logic [1:0] hsync;
    logic hprev;
    logic [SPD_W-1:0] spd;
    logic [SPD_W-1:0] hspd;
    logic [RATE_W-1:0] acc;
    logic [RATE_W-1:0] dec;
    logic dn;
  } main_state_t;

  main_state_t s;
  main_state_t next_s;
  ramp_if r ();
  logic [PH_W-1:0] ph_sum;
  logic home_rise;
  logic home_fall;
  logic accept;

  // -----------------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------------
  // stopping distance test: rem*2*dec*1000 <= v^2
  function automatic logic need_decel(input logic [POS_W-1:0] rem,
                                      input logic [SPD_W-1:0] v,
                                      input logic [RATE_W-1:0] d);
    logic [63:0] dist_term;
    logic [63:0] v_sq;
    dist_term = 64'(rem) * 64'(d) * 64'(2 * RATE_SCALE);
    v_sq = 64'(v) * 64'(v);
    return dist_term <= v_sq;
  endfunction : need_decel

  function automatic logic [SPD_W-1:0] home_speed(input logic [SPD_W-1:0] v);
    logic [SPD_W+7:0] prod;
    prod = (32'(v) * HOME_PCT) / PCT_FULL;
    return prod[SPD_W-1:0];
  endfunction : home_speed

  speed_ramp #(
    .TICKS(DIV_W'(TICK_LEN))
  ) u_ramp (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .r(r.gen)
  );

  assign home_rise = s.hsync[1] && !s.hprev;
  assign home_fall = !s.hsync[1] && s.hprev;
  assign accept = cmd_valid && (s.st == ST_IDLE);

  // -----------------------------------------------------------------------
  // sequencer, step generator and position
  // -----------------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.step = 1'b0;
    next_s.enc_ld = 1'b0;
    next_s.done = 1'b0;
    next_s.hsync = {s.hsync[0], home_in};
    next_s.hprev = s.hsync[1];
    r.clr = 1'b0;
    r.decel = 1'b0;
    r.tgt = s.spd;
    r.acc = s.acc;
    r.dec = s.dec;
    ph_sum = s.ph + PH_W'(r.speed);
    // steps at the commanded speed via phase accumulation
    if (s.st != ST_IDLE) begin
      if (ph_sum >= PH_WRAP) begin
        next_s.ph = ph_sum - PH_WRAP;
        next_s.step = 1'b1;
        next_s.pos = s.dir ? s.pos + 1'b1 : s.pos - 1'b1;
      end else begin
        next_s.ph = ph_sum;
      end
    end
    case (s.st)
      ST_IDLE: begin
        r.clr = 1'b1;
        next_s.ph = '0;
        if (accept) begin
          next_s.spd = cmd_speed;
          next_s.acc = cmd_accel;
          next_s.dec = cmd_decel;
          next_s.hspd = home_speed(cmd_speed);
          next_s.dn = 1'b0;
          case (cmd_op)
            OP_MOVE: begin
              next_s.dir = !cmd_value[POS_W-1];
              next_s.rem = cmd_value[POS_W-1] ? -cmd_value : cmd_value;
              if (cmd_value == '0) begin
                next_s.done = 1'b1;
              end else begin
                next_s.st = ST_RUN;
              end
            end
            OP_PRESET: begin
              next_s.pos = cmd_value;
              next_s.enc = cmd_value;
              next_s.enc_ld = 1'b1;
              next_s.done = 1'b1;
            end
            default: begin
              // already on home: start by backing off it
              next_s.hdir = (cmd_op == OP_HOME_CW);
              next_s.dir = s.hsync[1] ? (cmd_op != OP_HOME_CW) :
                (cmd_op == OP_HOME_CW);
              next_s.st = s.hsync[1] ? ST_BACK : ST_SEEK;
            end
          endcase
        end
      end
      ST_RUN: begin
        // ramp down once remaining steps reach the stopping distance
        // once begun the ramp down is kept, no climb back to full speed
        r.decel = s.dn || need_decel(s.rem, r.speed, s.dec);
        next_s.dn = r.decel;
        r.tgt = r.decel ? SPD_W'(s.dec) : s.spd;
        if (next_s.step) begin
          next_s.rem = s.rem - 1'b1;
          if (s.rem == 32'h0000_0001) begin
            next_s.st = ST_IDLE;
            next_s.done = 1'b1;
          end
        end
      end
      ST_SEEK: begin
        if (home_rise) begin
          next_s.st = ST_STOP1;
        end
      end
      ST_STOP1, ST_STOP2: begin
        r.decel = 1'b1;
        r.tgt = '0;
        if (r.speed == '0) begin
          next_s.wcnt = HOME_WAIT_TICKS;
          next_s.st = (s.st == ST_STOP1) ? ST_WAIT1 : ST_WAIT2;
        end
      end
      ST_WAIT1, ST_WAIT2: begin
        // stand still for the pause, counted in rate ticks
        r.clr = 1'b1;
        if (r.tick) begin
          next_s.wcnt = s.wcnt - 1'b1;
          if (s.wcnt == 12'h001) begin
            next_s.dir = (s.st == ST_WAIT1) ? !s.hdir : s.hdir;
            next_s.st = (s.st == ST_WAIT1) ? ST_BACK : ST_RET;
          end
        end
      end
      ST_BACK: begin
        if (home_fall) begin
          next_s.st = ST_STOP2;
        end
      end
      ST_RET: begin
        r.tgt = s.hspd;
        // only a trigger at homing speed in search direction counts
        if (home_rise && r.speed == s.hspd && s.dir == s.hdir) begin
          next_s.pos = '0;
          next_s.enc = '0;
          next_s.enc_ld = 1'b1;
          next_s.done = 1'b1;
          next_s.st = ST_IDLE;
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s <= '0;
      s.st <= ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // output drive
  assign cmd_ready = (s.st == ST_IDLE);
  assign cmd_done = s.done;
  assign busy = (s.st != ST_IDLE);
  assign step_pulse = s.step;
  assign step_cw = s.dir;
  assign speed_now = r.speed;
  assign profile_pos = s.pos;
  assign enc_load = s.enc_ld;
  assign enc_value = s.enc;

  // -----------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_home_sets_zero: assert property (
    ($past(s.st) == ST_RET && s.st == ST_IDLE)
    |-> (s.pos == '0 && s.enc == '0 && s.enc_ld && s.done))
    else $error("home end did not zero both positions");

  a_preset_both: assert property (
    (accept && cmd_op == OP_PRESET)
    |=> (s.pos == $past(cmd_value) && s.enc == $past(cmd_value)
         && s.enc_ld && s.st == ST_IDLE))
    else $error("preset did not load profile and encoder alike");

  a_speed_clamped: assert property (
    (s.st == ST_RUN) |-> (r.speed <= s.spd))
    else $error("speed passed the programmed speed");

  a_cw_start: assert property (
    (accept && cmd_op == OP_HOME_CW && !s.hsync[1])
    |=> (s.st == ST_SEEK && s.dir && s.hdir))
    else $error("clockwise search did not start clockwise");

  a_ccw_start: assert property (
    (accept && cmd_op == OP_HOME_CCW && !s.hsync[1])
    |=> (s.st == ST_SEEK && !s.dir && !s.hdir))
    else $error("counter-clockwise search did not start ccw");

  a_return_speed: assert property (
    (s.st == ST_RET) |-> (r.tgt == home_speed(s.spd) && s.dir == s.hdir))
    else $error("return segment not at homing speed");

  a_slow_only_end: assert property (
    (s.st == ST_RET && home_rise && r.speed != s.hspd) |=> s.st == ST_RET)
    else $error("search ended away from homing speed");

  a_pause_exit: assert property (
    (s.st == ST_WAIT1 && r.tick && s.wcnt == 12'h001)
    ##1 (s.st == ST_BACK) [*2] |-> s.dir == !s.hdir && r.speed == '0)
    else $error("pause did not end into reversal");

  a_run_decel: assert property (
    (s.st == ST_RUN && need_decel(s.rem, r.speed, s.dec) && r.tick
     && r.speed > SPD_W'(s.dec))
    |=> r.speed < $past(r.speed))
    else $error("no slowdown inside stopping distance");

  c_trapezoid: cover property (
    (s.st == ST_RUN && r.speed == s.spd) ##1 (s.st == ST_RUN && s.step));
  c_home_done: cover property (s.st == ST_RET ##1 s.st == ST_IDLE);
  c_preset: cover property (accept && cmd_op == OP_PRESET);

endmodule : move_profile_homing
`default_nettype wire

/* File: host_model.sv */
// host side model that offers commands to the profile block
`timescale 1ns/10ps
`default_nettype none
module host_model
  import move_profile_pkg::*;
(
  input wire logic ref_clk,              // system clock
  input wire logic cmd_ready,            // block idle
  output logic cmd_valid,                // command offered
  output op_t cmd_op,                    // command code
  output logic [POS_W-1:0] cmd_value,    // distance or preset
  output logic [SPD_W-1:0] cmd_speed,    // programmed speed
  output logic [RATE_W-1:0] cmd_accel,   // acceleration
  output logic [RATE_W-1:0] cmd_decel    // deceleration
);
  // -----------------------------------------------------------------
  // command driver
  // -----------------------------------------------------------------
  // quiet bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_op = OP_MOVE;
    cmd_value = 32'h0000_0000;
    cmd_speed = 24'h00_0000;
    cmd_accel = 16'h0000;
    cmd_decel = 16'h0000;
  end

  // offer one command; called just after a falling edge
  task automatic issue(input op_t op, input logic [POS_W-1:0] val,
                       input logic [SPD_W-1:0] spd,
                       input logic [RATE_W-1:0] ac,
                       input logic [RATE_W-1:0] dc);
    int n;
    n = 0;
    // a preset outside the 31-bit signed range, 32'hC000_0000 to 32'h3FFF_FFFF, is never sent
    if (op == OP_PRESET && ($signed(val) < $signed(32'hC000_0000) ||
        $signed(val) > $signed(32'h3FFF_FFFF))) return;
    cmd_op = op;
    cmd_value = val;
    cmd_speed = spd;
    cmd_accel = ac;
    cmd_decel = dc;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 100000) begin
      @(negedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    @(negedge ref_clk);
    // released operands carry no stale value
    cmd_valid = 1'b0;
    cmd_op = op_t'(~cmd_op);
    cmd_value = ~cmd_value;
    cmd_speed = ~cmd_speed;
    cmd_accel = ~cmd_accel;
    cmd_decel = ~cmd_decel;
  endtask : issue
endmodule : host_model
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the move profile and homing block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e, m) begin checks++; if ((a) !== (e)) begin \
  fail_count++; $display("wrong value at %0t: %s", $time, m); end end
module testbench
  import move_profile_pkg::*;
;
  // -----------------------------------------------------------------
  // signals and instances
  // -----------------------------------------------------------------
  localparam int TL = 5;
  localparam int WAIT_CYC = 2000 * TL;
  logic ref_clk, rstn, home_in, cmd_valid, cmd_ready, cmd_done, busy;
  logic step_pulse, step_cw, enc_load;
  op_t cmd_op;
  logic [POS_W-1:0] cmd_value, profile_pos, enc_value;
  logic [SPD_W-1:0] cmd_speed, speed_now, peak, last_spd, m_vp, sp_prev;
  logic [RATE_W-1:0] cmd_accel, cmd_decel, m_ac, m_dc;
  logic first_dir, last_dir, mon_on, ok;
  int fail_count, checks, cyc, abs_pos, nsteps, fstep, gap, maxgap;

  host_model host_u (.ref_clk(ref_clk), .cmd_ready(cmd_ready),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_value(cmd_value),
    .cmd_speed(cmd_speed), .cmd_accel(cmd_accel), .cmd_decel(cmd_decel));

  move_profile_homing #(.TICK_LEN(TL)) dut_u (.ref_clk(ref_clk),
    .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_value(cmd_value), .cmd_speed(cmd_speed),
    .cmd_accel(cmd_accel), .cmd_decel(cmd_decel), .cmd_done(cmd_done),
    .busy(busy), .home_in(home_in), .step_pulse(step_pulse),
    .step_cw(step_cw), .speed_now(speed_now), .profile_pos(profile_pos),
    .enc_load(enc_load), .enc_value(enc_value));

  // -----------------------------------------------------------------
  // clock, timeout and axis model
  // -----------------------------------------------------------------
  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  // cut a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 110000) begin
      fail_count++;
      conclude();
    end
  end

  // shaft position, home window sensor and step statistics
  always @(negedge ref_clk) begin
    if (step_pulse === 1'b1) begin
      abs_pos = abs_pos + (step_cw ? 1 : -1);
      if (nsteps == 0) first_dir = step_cw;
      nsteps++;
      last_dir = step_cw;
      last_spd = speed_now;
      if (speed_now === m_vp) fstep++;
    end
    if (busy === 1'b1 && step_pulse !== 1'b1) gap++;
    else gap = 0;
    if (gap > maxgap) maxgap = gap;
    if (busy === 1'b1 && speed_now > peak) peak = speed_now;
    // each speed change is one rate step or a clamp
    if (mon_on && speed_now !== sp_prev) begin
      if (speed_now > sp_prev) ok = (int'(speed_now) - int'(sp_prev) ==
          int'(m_ac)) || speed_now == m_vp;
      else ok = (int'(sp_prev) - int'(speed_now) == int'(m_dc)) ||
          speed_now == 24'(m_dc) || speed_now == 24'h00_0000;
      `CHK(ok, 1'b1, "ramp step size")
    end
    sp_prev = speed_now;
    home_in <= (abs_pos >= 100 && abs_pos <= 120);
  end

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task automatic conclude;
    if (fail_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic clr_stats(input logic [SPD_W-1:0] vp);
    nsteps = 0;
    fstep = 0;
    peak = 24'h00_0000;
    maxgap = 0;
    m_vp = vp;
  endtask : clr_stats

  // wait at falling edges for the done pulse
  task automatic wait_done(input int lim);
    int n;
    n = 0;
    while (cmd_done !== 1'b1 && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK(cmd_done, 1'b1, "command never finished")
  endtask : wait_done

  task automatic run_move(input logic [31:0] len, input logic [23:0] vp,
                          input logic [15:0] ac, input logic [15:0] dc);
    logic [31:0] p0;
    p0 = profile_pos;
    clr_stats(vp);
    m_ac = ac;
    m_dc = dc;
    sp_prev = speed_now;
    mon_on = 1'b1;
    host_u.issue(OP_MOVE, len, vp, ac, dc);
    wait_done(200000);
    mon_on = 1'b0;
    `CHK(profile_pos, p0 + len, "move length")
    @(negedge ref_clk);
    `CHK(speed_now, 24'h00_0000, "speed after move")
  endtask : run_move

  task automatic run_home(input op_t op);
    clr_stats(24'h06_1A80);
    host_u.issue(op, 32'h0000_0000, 24'h06_1A80, 16'hFDE8, 16'hFDE8);
    wait_done(100000);
    `CHK(profile_pos, 32'h0000_0000, "home position")
    `CHK(enc_load, 1'b1, "encoder load on home")
    `CHK(enc_value, 32'h0000_0000, "encoder value on home")
    `CHK(last_spd, 24'h00_9C40, "final homing speed")
    `CHK(maxgap >= WAIT_CYC && maxgap <= WAIT_CYC + 1500, 1'b1,
         "pause at stop")
  endtask : run_home

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_preset;
    host_u.issue(OP_PRESET, 32'hC000_0000, 24'h00_0000, 16'h0000, 16'h0000);
    wait_done(4);
    `CHK(profile_pos, 32'hC000_0000, "preset low bound")
    `CHK(enc_value, 32'hC000_0000, "encoder low bound")
    `CHK(enc_load, 1'b1, "encoder load on preset")
    @(negedge ref_clk);
    host_u.issue(OP_PRESET, 32'h3FFF_FFFF, 24'h00_0000, 16'h0000, 16'h0000);
    wait_done(4);
    `CHK(profile_pos, 32'h3FFF_FFFF, "preset high bound")
    `CHK(enc_value, 32'h3FFF_FFFF, "encoder high bound")
    @(negedge ref_clk);
  endtask : t_preset

  // long move: flat run at full speed, then stopping distance
  task automatic t_trap;
    longint dd;
    dd = longint'(60000) * 60000 / (2 * 1000 * 50000);
    run_move(32'h0000_0032, 24'h00_EA60, 16'h4E20, 16'hC350);
    `CHK(peak, 24'h00_EA60, "peak speed")
    `CHK(fstep >= 50 - dd - 2 && fstep <= 50 - dd + 2, 1'b1,
         "steps at full speed")
    `CHK(first_dir, 1'b1, "move direction")
  endtask : t_trap

  // short reverse move never reaches the programmed speed
  task automatic t_tri;
    run_move(32'hFFFF_FFFD, 24'h00_EA60, 16'h4E20, 16'h2710);
    `CHK(peak < 24'h00_EA60, 1'b1, "triangle peak")
    `CHK(fstep, 0, "no flat run")
    `CHK(last_dir, 1'b0, "reverse direction")
  endtask : t_tri

  task automatic t_home_cw;
    run_home(OP_HOME_CW);
    `CHK(first_dir, 1'b1, "search starts clockwise")
    `CHK(last_dir, 1'b1, "search ends clockwise")
    `CHK(abs_pos, 100, "stop on rising home edge")
    @(negedge ref_clk);
  endtask : t_home_cw

  // home already active: starts moving away, ends counter-clockwise
  task automatic t_home_ccw;
    run_home(OP_HOME_CCW);
    `CHK(first_dir, 1'b1, "leaves active home first")
    `CHK(last_dir, 1'b0, "search ends counter-clockwise")
    `CHK(abs_pos, 120, "stop on far home edge")
  endtask : t_home_ccw

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    home_in = 1'b0;
    mon_on = 1'b0;
    fail_count = 0;
    checks = 0;
    cyc = 0;
    abs_pos = 0;
    gap = 0;
    clr_stats(24'h00_0000);
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn = 1'b1;
    @(negedge ref_clk);
    t_preset();
    t_trap();
    t_tri();
    t_home_cw();
    t_home_ccw();
    conclude();
  end
endmodule : testbench
`default_nettype wire
